// file: src/ram_pkg.sv
// Shared types and constants for the embedded RAM block.
// Assumes a single fabric clock and a synchronous, active-high reset.
package ram_pkg;
  // ******************************************************
  // Array geometry
  // ******************************************************
  localparam int ARRAY_BITS  = 9216;     // Capacity with the ninth bits
  localparam int NARROW_BITS = 8192;     // Capacity for 1, 2 and 4 bit words
  localparam int WIDTH_9     = 9;        // Narrowest width with ninth bit
  localparam int WIDTH_18    = 18;       // Widest width, pseudo dual / FIFO only
  localparam int ADDR_W      = 13;       // Word address width on each port
  localparam int DATA_W      = 18;       // Data carried in a request
  localparam int BIT_W       = 14;       // Bit index into the array
  localparam int LEVEL_W     = 15;       // FIFO fill level in bits
  // ******************************************************
  // Initial load from the user flash store
  // ******************************************************
  localparam int INIT_W      = 9;        // Bits per flash word
  localparam int INIT_WORDS  = 1024;     // Words in one full image
  localparam int FLASH_AW    = 12;       // Flash word address width
  localparam int IDX_W       = 10;       // Load word counter width

  // Block operating modes
  typedef enum logic [1:0] {
    RAM_SINGLE, RAM_TRUE_DUAL, RAM_PSEUDO_DUAL, RAM_FIFO
  } ram_mode_t;

  // One port request as captured by the input registers
  typedef struct packed {
    logic              en;     // Port select from outside decode
    logic              we;     // Write enable (push in FIFO mode)
    logic [ADDR_W-1:0] addr;   // Word address
    logic [DATA_W-1:0] wdata;  // Write data, low bits used
  } ram_req_t;

  // Capacity in bits seen by a port of width w
  function automatic int cap_bits(input int w);
    cap_bits = (w == WIDTH_9 || w == WIDTH_18) ? ARRAY_BITS : NARROW_BITS;
  endfunction : cap_bits

  // Legal width for the given mode
  function automatic logic width_ok(input int w, input ram_mode_t m);
    width_ok = (w == 1 || w == 2 || w == 4 || w == WIDTH_9) ||
               (w == WIDTH_18 && (m == RAM_PSEUDO_DUAL || m == RAM_FIFO));
  endfunction : width_ok
endpackage : ram_pkg

// file: src/ram_block.sv
// Embedded RAM block: single, true dual, pseudo dual port and FIFO modes.
// Assumes fabric user logic on one clock drives both ports synchronously.
`timescale 1ns/1ns
`default_nettype none
module ram_block #(
  parameter ram_pkg::ram_mode_t MODE = ram_pkg::RAM_TRUE_DUAL, // Operating mode
  parameter int WA        = 9,          // Port A data width
  parameter int WB        = 9,          // Port B data width
  parameter bit OUT_REG   = 1'b0,       // Output register enable
  parameter bit INIT_LOAD = 1'b0,       // Load image from flash
  parameter logic [ram_pkg::FLASH_AW-1:0] INIT_BASE = 12'h000 // Image start
) (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst,
  // Port A: read/write except in pseudo dual mode, FIFO push side
  input  wire ram_pkg::ram_req_t            a_req,
  output logic [WA-1:0]                     a_rdata,
  // Port B: read/write in true dual mode only, read elsewhere, FIFO pop side
  input  wire ram_pkg::ram_req_t            b_req,
  output logic [WB-1:0]                     b_rdata,
  // FIFO flags
  output logic                              fifo_full,
  output logic                              fifo_empty,
  // User flash store load path
  output logic                              flash_req,
  output logic [ram_pkg::FLASH_AW-1:0]      flash_addr,
  input  wire logic                         flash_ack,
  input  wire logic [ram_pkg::INIT_W-1:0]   flash_data,
  // Status
  output logic                              ready,
  output logic                              cfg_error
);
  // ******************************************************
  // Configuration
  // ******************************************************
  localparam int CAP_A   = ram_pkg::cap_bits(WA);     // Bits behind port A
  localparam int CAP_B   = ram_pkg::cap_bits(WB);     // Bits behind port B
  localparam int DEPTH_A = CAP_A / WA;                // Words on port A
  localparam int DEPTH_B = CAP_B / WB;                // Words on port B
  localparam logic [ram_pkg::LEVEL_W-1:0] CAP_L = ram_pkg::LEVEL_W'(CAP_A);
  localparam logic [ram_pkg::LEVEL_W-1:0] WA_L  = ram_pkg::LEVEL_W'(WA);
  localparam logic [ram_pkg::LEVEL_W-1:0] WB_L  = ram_pkg::LEVEL_W'(WB);
  localparam logic [ram_pkg::IDX_W-1:0]   LAST  = ram_pkg::IDX_W'(ram_pkg::INIT_WORDS - 1);

  // Shape check; mixed ports need one capacity class outside single mode
  assign cfg_error = !ram_pkg::width_ok(WA, MODE) || !ram_pkg::width_ok(WB, MODE) ||
                     (MODE != ram_pkg::RAM_SINGLE && CAP_A != CAP_B);

  // Load sequencer states
  typedef enum logic {RAM_ST_LOAD, RAM_ST_RUN} ram_state_t;

  // ******************************************************
  // Storage and input registers
  // ******************************************************
  logic [ram_pkg::ARRAY_BITS-1:0] mem;        // Linear bit array
  ram_pkg::ram_req_t              a_q;        // Captured port A request
  ram_pkg::ram_req_t              b_q;        // Captured port B request
  ram_state_t                     state;      // Load or run
  logic [ram_pkg::IDX_W-1:0]      idx;        // Load word index
  logic [ram_pkg::LEVEL_W-1:0]    level;      // FIFO fill in bits
  logic [ram_pkg::BIT_W-1:0]      wr_ptr;     // FIFO push bit pointer
  logic [ram_pkg::BIT_W-1:0]      rd_ptr;     // FIFO pop bit pointer
  logic [WA-1:0]                  a_out;      // Port A output register
  logic [WB-1:0]                  b_out;      // Port B output register

  assign ready = (state == RAM_ST_RUN);

  // Capture requests once ready, zero while loading; the array sees only these copies
  always_ff @(posedge clk) begin
    if (rst) begin
      a_q <= '0;
      b_q <= '0;
    end else begin
      a_q <= ready ? a_req : '0;
      b_q <= ready ? b_req : '0;
    end
  end

  // ******************************************************
  // Address decode
  // ******************************************************
  wire is_fifo   = (MODE == ram_pkg::RAM_FIFO);
  wire a_in_rng  = int'(a_q.addr) < DEPTH_A;            // Outside decode picks block
  wire b_in_rng  = int'(b_q.addr) < DEPTH_B;
  // Word n starts at bit n*width on each port's own view
  wire [ram_pkg::BIT_W-1:0] a_bit = is_fifo ? wr_ptr :
                                    ram_pkg::BIT_W'(int'(a_q.addr) * WA);
  wire [ram_pkg::BIT_W-1:0] b_bit = is_fifo ? rd_ptr :
                                    ram_pkg::BIT_W'(int'(b_q.addr) * WB);

  // Per-mode port roles
  wire b_allowed = (MODE != ram_pkg::RAM_SINGLE);
  wire a_wr_req  = a_q.en && a_q.we && (is_fifo || a_in_rng);
  wire b_wr_req  = b_allowed && b_q.en && b_q.we && b_in_rng &&
                   (MODE == ram_pkg::RAM_TRUE_DUAL);
  wire push_ok   = is_fifo && a_wr_req && !fifo_full;
  wire pop_ok    = is_fifo && b_q.en && !fifo_empty;
  wire a_wr      = is_fifo ? push_ok : a_wr_req && MODE != ram_pkg::RAM_PSEUDO_DUAL;
  wire b_wr      = b_wr_req;

  // Full when the next word will not fit, empty when a whole word is not there
  assign fifo_full  = is_fifo && (level + WA_L > CAP_L);
  assign fifo_empty = !is_fifo || (level < WB_L);

  // ******************************************************
  // Array write and initial load
  // ******************************************************
  // Port A written last, so it wins a same-bit collision with port B
  always_ff @(posedge clk) begin
    if (rst) begin
      mem <= '0;
    end else if (state == RAM_ST_LOAD) begin
      if (flash_ack) begin
        mem[idx * ram_pkg::INIT_W +: ram_pkg::INIT_W] <= flash_data;
      end
    end else begin
      if (b_wr) begin
        mem[b_bit +: WB] <= b_q.wdata[WB-1:0];
      end
      if (a_wr) begin
        mem[a_bit +: WA] <= a_q.wdata[WA-1:0];
      end
    end
  end

  // Load sequencer; zero images skip the flash entirely
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= INIT_LOAD ? RAM_ST_LOAD : RAM_ST_RUN;
      idx   <= '0;
    end else if (state == RAM_ST_LOAD && flash_ack) begin
      idx <= idx + 1'b1;
      if (idx == LAST) begin
        state <= RAM_ST_RUN;
      end
    end
  end

  // Image address is relative to a shared base, so blocks can point at one copy
  assign flash_req  = (state == RAM_ST_LOAD);
  assign flash_addr = INIT_BASE + ram_pkg::FLASH_AW'(idx);

  // ******************************************************
  // FIFO pointers
  // ******************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level  <= '0;
    end else begin
      if (push_ok) begin
        wr_ptr <= (int'(wr_ptr) + WA >= CAP_A) ? '0 : wr_ptr + ram_pkg::BIT_W'(WA);
      end
      if (pop_ok) begin
        rd_ptr <= (int'(rd_ptr) + WB >= CAP_A) ? '0 : rd_ptr + ram_pkg::BIT_W'(WB);
      end
      level <= level + (push_ok ? WA_L : '0) - (pop_ok ? WB_L : '0);
    end
  end

  // ******************************************************
  // Read path
  // ******************************************************
  wire [WA-1:0] a_raw = mem[a_bit +: WA]; // Array output, port A
  wire [WB-1:0] b_raw = mem[b_bit +: WB]; // Array output, port B

  // Optional output register; trades a cycle of latency for timing
  always_ff @(posedge clk) begin
    if (rst) begin
      a_out <= '0;
      b_out <= '0;
    end else begin
      a_out <= a_raw;
      b_out <= b_raw;
    end
  end

  assign a_rdata = OUT_REG ? a_out : a_raw;
  assign b_rdata = OUT_REG ? b_out : b_raw;

  // ******************************************************
  // Checks
  // ******************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Last flash word closes the load in one cycle
  sequence load_last_s;
    flash_req && flash_ack && idx == LAST;
  endsequence
  sequence run_next_s;
    ##1 (ready && !flash_req);
  endsequence

  load_done_a: assert property (load_last_s |-> run_next_s)
    else $error("load did not finish on last flash word");
  zero_image_a: assert property (!INIT_LOAD |-> !flash_req)
    else $error("zero image requested flash data");
  image_base_a: assert property (
      flash_req |-> flash_addr - INIT_BASE == ram_pkg::FLASH_AW'(idx))
    else $error("flash address not relative to image base");
  // A capture made under reset holds zero, not the pin value
  capture_a: assert property (
      ready && $past(ready) && !$past(rst) |-> a_q == $past(a_req))
    else $error("port A request not captured");
  out_lat_a: assert property (OUT_REG |=> a_rdata == $past(a_raw))
    else $error("output register latency wrong");
  full_block_a: assert property (
      fifo_full && !pop_ok |=> $stable(wr_ptr) && $stable(level))
    else $error("push accepted while full");
  empty_block_a: assert property (
      fifo_empty && !push_ok |=> $stable(rd_ptr) && $stable(level))
    else $error("pop accepted while empty");
  write_land_a: assert property (
      a_wr && ready |=> mem[$past(a_bit) +: WA] == $past(a_q.wdata[WA-1:0]))
    else $error("port A write did not land");
  shape_ok_a: assert property (!cfg_error)
    else $error("illegal width for this mode");
endmodule : ram_block
`default_nettype wire

// file: sim/ram_flash_model.sv
// Behavioural user flash store that feeds the RAM's initial load.
// Assumes the fabric clock and one answer pulse per requested word.
`timescale 1ns/1ns
`default_nettype none
module ram_flash_model #(
  parameter int DELAY = 1  // Wait count; ack stays low DELAY+1 cycles before each answer
) (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst,
  // Load path from the RAM
  input  wire logic                         flash_req,
  input  wire logic [ram_pkg::FLASH_AW-1:0] flash_addr,
  output logic                              flash_ack,
  output logic [ram_pkg::INIT_W-1:0]        flash_data
);
  // ******************************
  // Answer logic
  // ******************************
  int cnt;  // Wait toward the next answer
  initial begin
    flash_ack  = 1'h0;
    flash_data = 9'h1AA;
    cnt        = 0;
  end
  // Data toggles outside answers so a stale sample cannot pass
  always @(posedge clk) begin
    if (flash_ack) begin
      flash_ack  <= 1'h0;
      flash_data <= ~flash_data;
    end else if (flash_req && !rst && cnt >= DELAY) begin
      flash_ack  <= 1'h1;
      flash_data <= 9'(flash_addr * 7 + 3);
      cnt        <= 0;
    end else begin
      cnt        <= (flash_req && !rst) ? cnt + 1 : 0;
      flash_data <= ~flash_data;
    end
  end
endmodule : ram_flash_model
`default_nettype wire

// file: sim/tb.sv
// Bench: 4/1-bit true dual port with flash image, then a 9-bit FIFO.
// Assumes ram_flash_model answers the load of the dual-port block.
`timescale 1ns/1ns
`default_nettype none
module tb;
  // ******************************
  // Signals
  // ******************************
  localparam logic [11:0] BASE = 12'h040;      // Image base in flash
  logic              clk, rst;                 // Clock, reset
  ram_pkg::ram_req_t a_req, b_req;             // Dual-port requests
  ram_pkg::ram_req_t fa_req, fb_req;           // FIFO push, pop
  logic [3:0]        a_rdata, last_a;          // Nibble port, previous read
  logic [0:0]        b_rdata;                  // Bit port
  logic [8:0]        fb_rdata, fdata;          // FIFO head, flash word
  logic [11:0]       faddr;                    // Flash address
  logic              freq, fack, ready, cerr;  // Load status
  logic              ffull, fempty, fz, has_prev;
  logic              dfull, dempty, fready, fcerr; // Flags of the other roles
  logic              shadow [8192];            // Expected array bits
  int                n_errors, cmp_count;      // Tallies
  ram_block #(.MODE(ram_pkg::RAM_TRUE_DUAL), .WA(4), .WB(1), .OUT_REG(1'h1),
              .INIT_LOAD(1'h1), .INIT_BASE(BASE)) dut (
    .clk(clk), .rst(rst), .a_req(a_req), .a_rdata(a_rdata), .b_req(b_req), .b_rdata(b_rdata),
    .fifo_full(dfull), .fifo_empty(dempty), .flash_req(freq), .flash_addr(faddr), .flash_ack(fack),
    .flash_data(fdata), .ready(ready), .cfg_error(cerr));
  ram_flash_model #(.DELAY(1)) flash (.clk(clk), .rst(rst), .flash_req(freq),
    .flash_addr(faddr), .flash_ack(fack), .flash_data(fdata));
  ram_block #(.MODE(ram_pkg::RAM_FIFO), .WA(9), .WB(9)) dut_fifo (
    .clk(clk), .rst(rst), .a_req(fa_req), .a_rdata(), .b_req(fb_req), .b_rdata(fb_rdata),
    .fifo_full(ffull), .fifo_empty(fempty), .flash_req(fz), .flash_addr(), .flash_ack(fack),
    .flash_data(fdata), .ready(fready), .cfg_error(fcerr));
  always #5 clk = ~clk;  // 100 MHz
  // Bit b of the flash image, nine bits per flash word
  function automatic logic img_bit(input int b);
    logic [8:0] w;
    w = 9'((int'(BASE) + b / 9) * 7 + 3);
    return w[b % 9];
  endfunction : img_bit
  task automatic check(input logic [17:0] got, input logic [17:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("compares %0d, errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  // One cycle on both ports; the shadow follows the writes
  task automatic wr(input logic wa, input int na, input logic [3:0] da,
                    input logic wb, input int nb, input logic db);
    @(posedge clk);
    a_req <= '{wa, wa, 13'(na), 18'(da)};
    b_req <= '{wb, wb, 13'(nb), 18'(db)};
    for (int k = 0; k < 4; k++) if (wa) shadow[na * 4 + k] = da[k];
    if (wb) shadow[nb] = db;
    has_prev = 1'h0;
  endtask : wr
  // Read both ports; output register holds the old word one edge longer
  task automatic rd(input int na, input int nb);
    logic [3:0] exp;
    exp = {shadow[na*4+3], shadow[na*4+2], shadow[na*4+1], shadow[na*4]};
    @(posedge clk);
    a_req <= '{1'h1, 1'h0, 13'(na), 18'h0};
    b_req <= '{1'h1, 1'h0, 13'(nb), 18'h0};
    @(posedge clk);
    #1;
    if (has_prev) check(18'(a_rdata), 18'(last_a), "early output");
    @(posedge clk);
    #1;
    check(18'(a_rdata), 18'(exp), "nibble word");
    check(18'(b_rdata), 18'(shadow[nb]), "single bit");
    last_a = exp;
    has_prev = 1'h1;
  endtask : rd
  task automatic t_load;  // Image arrives, then the flash is let go
    int wa[4] = '{0, 1, 2047, 1000};
    int wb[4] = '{0, 9, 8191, 4001};
    for (int n = 0; n < 5000 && ready !== 1'h1; n++) @(posedge clk);
    #1;
    check(18'(ready), 18'h1, "load done");
    check(18'(freq), 18'h0, "flash released");
    check(18'(cerr), 18'h0, "legal shape");
    check(18'(dfull), 18'h0, "no full outside fifo");
    check(18'(dempty), 18'h1, "empty outside fifo");
    foreach (wa[i]) rd(wa[i], wb[i]);
  endtask : t_load
  task automatic t_ports;  // Different addresses on each port only
    wr(1'h1, 10, 4'h5, 1'h1, 100, ~shadow[100]);
    wr(1'h0, 0, 4'h0, 1'h1, 41, 1'h1);
    // Beyond the depth; its bit index would alias nibble 10 if let through
    @(posedge clk);
    a_req <= '{1'h1, 1'h1, 13'h100A, 18'h0000A};
    rd(10, 40);
    rd(25, 100);
    rd(10, 43);
  endtask : t_ports
  task automatic t_fifo;  // Overfill, overdrain, head must survive both
    check(18'(fempty), 18'h1, "empty at start");
    check(18'(fz), 18'h0, "zero image needs no flash");
    check(18'(fready), 18'h1, "zero image runs at once");
    check(18'(fcerr), 18'h0, "legal fifo shape");
    for (int i = 0; i < 1027; i++) begin
      @(posedge clk);
      fa_req <= (i < 1026) ? '{1'h1, 1'h1, 13'h0, 18'(i)} : '0;
    end
    repeat (2) @(posedge clk);
    #1;
    check(18'(ffull), 18'h1, "full at capacity");
    for (int i = 0; i < 1025; i++) begin
      if (i < 1024) check(18'(fb_rdata), 18'(i[8:0]), "fifo order");
      @(posedge clk);
      fb_req <= '{1'h1, 1'h0, 13'h0, 18'h0};
      @(posedge clk);
      fb_req <= '0;
      @(posedge clk);
      #1;
      if (i == 0) check(18'(ffull), 18'h0, "full drops");
    end
    check(18'(fempty), 18'h1, "empty after drain");
    @(posedge clk);
    fa_req <= '{1'h1, 1'h1, 13'h0, 18'h077};
    @(posedge clk);
    fa_req <= '0;
    repeat (2) @(posedge clk);
    #1;
    check(18'(fb_rdata), 18'h077, "head after refused pop");
  endtask : t_fifo
  // Main sequence
  initial begin
    clk = 1'h0;
    rst = 1'h1;
    {a_req, b_req, fa_req, fb_req} = '0;
    {n_errors, cmp_count, has_prev, last_a} = '0;
    for (int b = 0; b < 8192; b++) shadow[b] = img_bit(b);
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    #1;
    check(18'(faddr), 18'(BASE), "load starts at base");
    t_load();
    t_ports();
    t_fifo();
    tally_and_finish();
  end
  // Watchdog, well beyond the expected run
  initial begin
    #300000;
    n_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
